/* bench/spcb_bank_props.sv */
// concurrent checks on the ports of the servo protection config bank
`timescale 1ns/1ns
module spcb_bank_props
    import spcb_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic par_wr_i,
    input wire logic par_rd_i,
    input wire logic [SPCB_AW-1:0] par_addr_i,
    input wire logic [SPCB_DW-1:0] par_wdata_i,
    input wire logic [SPCB_DW-1:0] par_rdata_o,
    input wire logic par_ack_o,
    input wire logic par_err_o,
    input wire logic [15:0] special_function_code_i,
    input wire logic home_set_o,
    input wire logic wire_cut_det_i,
    input wire logic wire_cut_alarm_o,
    input wire logic phase_loss_det_i,
    input wire logic phase_loss_alarm_o,
    input wire logic speed_below_zero_threshold_i,
    input wire logic [15:0] friction_comp_i,
    input wire logic [15:0] friction_comp_o,
    input wire logic alarm_output_pin_o,
    input wire logic warning_output_pin_o,
    input wire logic position_overflow_i,
    input wire logic user_unit_overflow_warning_o,
    input wire logic pulse_unit_overflow_warning_o,
    input wire logic absolute_mode_o,
    input wire logic wrong_motor_alarm_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    wire par_acc = par_wr_i | par_rd_i;
    wire par_hit = par_addr_i inside {SPCB_ADDR_SPECIAL_ONE, SPCB_ADDR_SPECIAL_TWO, SPCB_ADDR_SETTLE_THR,
        SPCB_ADDR_TRACK_MODE, SPCB_ADDR_READBACK_UNIT, SPCB_ADDR_HOME_SET};
    wire ovf_any = user_unit_overflow_warning_o | pulse_unit_overflow_warning_o;

    a_map_ack: assert property (par_acc && par_hit |=> par_ack_o && !par_err_o)
        else $error("mapped access without ack");
    a_unmap_err: assert property (par_acc && !par_hit |=> par_err_o && !par_ack_o)
        else $error("unmapped access without err");
    a_rdata_idle: assert property (!par_ack_o |-> par_rdata_o == 16'h0000)
        else $error("read data outside ack");
    a_wire_cut_cause: assert property (wire_cut_alarm_o |-> $past(wire_cut_det_i))
        else $error("wire cut alarm without detector");
    a_phase_loss_cause: assert property (phase_loss_alarm_o |-> $past(phase_loss_det_i))
        else $error("phase loss alarm without detector");
    a_friction_pass: assert property ($past(resetn_i) && !$past(speed_below_zero_threshold_i)
        |-> friction_comp_o == $past(friction_comp_i)) else $error("friction value not passed");
    a_uv_pin_excl: assert property (alarm_output_pin_o |-> !warning_output_pin_o)
        else $error("both undervoltage pins on");
    a_ovf_cause: assert property (ovf_any |-> $past(position_overflow_i) && !(user_unit_overflow_warning_o
        && pulse_unit_overflow_warning_o)) else $error("overflow warning wrong");
    a_home_cause: assert property (home_set_o |-> $past(par_wr_i) && $past(par_wdata_i) == 16'h0001
        && $past(par_addr_i) == SPCB_ADDR_HOME_SET && $past(special_function_code_i) == SPCB_HOME_FUNC_CODE)
        else $error("home set without valid trigger");
    a_mode_frozen: assert property ($past(resetn_i, 3) |-> $stable(absolute_mode_o))
        else $error("tracking mode changed without power-up");
    a_wrong_motor_mode: assert property (wrong_motor_alarm_o |-> absolute_mode_o)
        else $error("wrong motor alarm in incremental mode");

    c_home: cover property (home_set_o);
    c_err: cover property (par_err_o);
    c_uv_alarm: cover property (alarm_output_pin_o);
endmodule
bind spcb_bank spcb_bank_props i_spcb_bank_props (
    .ref_clk_i, .resetn_i, .par_wr_i, .par_rd_i, .par_addr_i, .par_wdata_i, .par_rdata_o, .par_ack_o,
    .par_err_o, .special_function_code_i, .home_set_o, .wire_cut_det_i, .wire_cut_alarm_o, .phase_loss_det_i,
    .phase_loss_alarm_o, .speed_below_zero_threshold_i, .friction_comp_i, .friction_comp_o, .alarm_output_pin_o,
    .warning_output_pin_o, .position_overflow_i, .user_unit_overflow_warning_o, .pulse_unit_overflow_warning_o,
    .absolute_mode_o, .wrong_motor_alarm_o
);

/* bench/spcb_bank_tb_top.sv */
// self-checking bench for the servo protection config bank
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module spcb_bank_tb_top import spcb_pkg::*;;
    logic ref_clk_i, resetn_i, par_wr_i, par_rd_i, nv_track_mode_i, motor_is_absolute_i, semi_auto_mode_i;
    logic speed_below_zero_threshold_i, pulse_err_det_i, wire_cut_det_i, phase_loss_det_i, encoder_output_det_i;
    logic ignorable_fault_det_i, undervoltage_det_i, alarm_clear_i, position_overflow_i;
    logic [15:0] par_addr_i, par_wdata_i, special_function_code_i, inertia_estimate_i, friction_comp_i;
    logic [15:0] par_rdata_o, friction_comp_o, w1, w2, ru, d;
    logic [8:0] alm;
    logic par_ack_o, par_err_o, pulse_err_alarm_o, wire_cut_alarm_o, phase_loss_alarm_o, encoder_output_alarm_o;
    logic ignorable_fault_alarm_o, undervoltage_alarm_o, alarm_output_pin_o, warning_output_pin_o;
    logic wrong_motor_alarm_o, absolute_mode_o, dio_unit_pulse_o, comm_unit_pulse_o, inertia_done_o, home_set_o;
    logic user_unit_overflow_warning_o, pulse_unit_overflow_warning_o;
    int errors, comparisons;

    // short settle count keeps the run brief
    spcb_bank #(.SETTLE_CYC(8)) i_spcb_bank (
        .ref_clk_i, .resetn_i, .par_wr_i, .par_rd_i, .par_addr_i, .par_wdata_i, .par_rdata_o, .par_ack_o,
        .par_err_o, .nv_track_mode_i, .special_function_code_i, .motor_is_absolute_i, .semi_auto_mode_i,
        .inertia_estimate_i, .speed_below_zero_threshold_i, .friction_comp_i, .pulse_err_det_i, .wire_cut_det_i,
        .phase_loss_det_i, .encoder_output_det_i, .ignorable_fault_det_i, .undervoltage_det_i, .alarm_clear_i,
        .position_overflow_i, .pulse_err_alarm_o, .wire_cut_alarm_o, .phase_loss_alarm_o, .encoder_output_alarm_o,
        .ignorable_fault_alarm_o, .undervoltage_alarm_o, .alarm_output_pin_o, .warning_output_pin_o,
        .wrong_motor_alarm_o, .absolute_mode_o, .friction_comp_o, .dio_unit_pulse_o, .comm_unit_pulse_o,
        .user_unit_overflow_warning_o, .pulse_unit_overflow_warning_o, .inertia_done_o, .home_set_o
    );

    initial begin
        ref_clk_i = 0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic step(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] dat);
        @(negedge ref_clk_i);
        par_wr_i = w;
        par_rd_i = !w;
        par_addr_i = a;
        par_wdata_i = dat;
        @(negedge ref_clk_i);
        par_wr_i = 0;
        par_rd_i = 0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        acc(0, a, 16'h0000);
        `CHK("read", {1'b1, e}, {par_ack_o, par_rdata_o})
    endtask
    task automatic do_reset(input logic nv);
        nv_track_mode_i = nv;
        resetn_i = 0;
        step(6);
        resetn_i = 1;
        step(2);
    endtask
    task automatic print_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [8:0] exp_det(input logic [15:0] a, b, u, input logic [6:0] t);
        exp_det = {t[6] & !a[6], t[5] & a[9], t[4] & !a[12], t[3] & !a[13], t[2] & !b[4],
            t[1] & !u[2] & !u[1], t[1] & !u[2] & u[1], u[0], u[1]};
    endfunction

    initial begin
        #(100 * 20000);
        errors++;
        print_verdict();
    end

    initial begin
        {par_wr_i, par_rd_i, nv_track_mode_i, motor_is_absolute_i, semi_auto_mode_i} = '0;
        {pulse_err_det_i, wire_cut_det_i, phase_loss_det_i, encoder_output_det_i, ignorable_fault_det_i} = '0;
        {undervoltage_det_i, alarm_clear_i, position_overflow_i, par_addr_i, par_wdata_i} = '0;
        {special_function_code_i, inertia_estimate_i, friction_comp_i, speed_below_zero_threshold_i} = '0;
        void'($urandom(32'h62e26a82));
        do_reset(0);
        rd(SPCB_ADDR_SPECIAL_ONE, SPCB_RST_SPECIAL_ONE);
        rd(SPCB_ADDR_SPECIAL_TWO, SPCB_RST_SPECIAL_TWO);
        rd(SPCB_ADDR_SETTLE_THR, SPCB_RST_SETTLE_THR);
        rd(SPCB_ADDR_TRACK_MODE, 16'h0000);
        rd(SPCB_ADDR_READBACK_UNIT, SPCB_RST_READBACK_UNIT);
        rd(SPCB_ADDR_HOME_SET, 16'h0000);
        acc(0, 16'h0288, 16'h0000);
        `CHK("unmapped", 18'h2_0000, {par_err_o, par_ack_o, par_rdata_o})
        for (int i = 0; i < 30; i++) begin
            w1 = (i == 0) ? 16'hffff : 16'($urandom);
            w2 = (i == 0) ? 16'hffff : 16'($urandom);
            ru = 16'($urandom) & 16'h0007;
            acc(1, SPCB_ADDR_SPECIAL_ONE, w1);
            acc(1, SPCB_ADDR_SPECIAL_TWO, w2);
            acc(1, SPCB_ADDR_READBACK_UNIT, ru);
            rd(SPCB_ADDR_SPECIAL_ONE, w1 & SPCB_MASK_SPECIAL_ONE);
            rd(SPCB_ADDR_SPECIAL_TWO, w2 & SPCB_MASK_SPECIAL_TWO);
            rd(SPCB_ADDR_READBACK_UNIT, ru);
            d = (i == 1) ? 16'h007f : 16'($urandom);
            {pulse_err_det_i, wire_cut_det_i, phase_loss_det_i, encoder_output_det_i} = d[6:3];
            {ignorable_fault_det_i, position_overflow_i, speed_below_zero_threshold_i} = d[2:0];
            friction_comp_i = 16'($urandom);
            step(1);
            alm = {pulse_err_alarm_o, wire_cut_alarm_o, phase_loss_alarm_o, encoder_output_alarm_o,
                ignorable_fault_alarm_o, user_unit_overflow_warning_o, pulse_unit_overflow_warning_o,
                dio_unit_pulse_o, comm_unit_pulse_o};
            `CHK("alarms", exp_det(w1, w2, ru, d[6:0]), alm)
            `CHK("friction", (d[0] && w1[15]) ? 16'h0000 : friction_comp_i, friction_comp_o)
        end
        // out of range threshold must not overwrite the held value
        acc(1, SPCB_ADDR_SETTLE_THR, 16'h07d1);
        rd(SPCB_ADDR_SETTLE_THR, SPCB_RST_SETTLE_THR);
        acc(1, SPCB_ADDR_SETTLE_THR, SPCB_SETTLE_THR_MAX);
        rd(SPCB_ADDR_SETTLE_THR, SPCB_SETTLE_THR_MAX);
        acc(1, SPCB_ADDR_SETTLE_THR, 16'h0005);
        semi_auto_mode_i = 1;
        inertia_estimate_i = 16'h0004;
        step(8);
        `CHK("settle_early", 1'b0, inertia_done_o)
        step(1);
        `CHK("settle_done", 1'b1, inertia_done_o)
        inertia_estimate_i = 16'h0005;
        step(2);
        `CHK("settle_drop", 1'b0, inertia_done_o)
        for (int k = 0; k < 2; k++) begin
            acc(1, SPCB_ADDR_SPECIAL_TWO, k ? 16'h0204 : 16'h0000);
            undervoltage_det_i = 1;
            step(2);
            `CHK("uv_on", {1'b1, k[0], !k[0]}, {undervoltage_alarm_o, alarm_output_pin_o, warning_output_pin_o})
            undervoltage_det_i = 0;
            step(2);
            `CHK("uv_off", k ? 3'b000 : 3'b101, {undervoltage_alarm_o, alarm_output_pin_o, warning_output_pin_o})
            alarm_clear_i = 1;
            step(2);
            alarm_clear_i = 0;
            `CHK("uv_clr", 3'b000, {undervoltage_alarm_o, alarm_output_pin_o, warning_output_pin_o})
        end
        for (int k = 0; k < 2; k++) begin
            special_function_code_i = 16'h010e + 16'(k);
            acc(1, SPCB_ADDR_HOME_SET, 16'h0001);
            `CHK("home", k[0], home_set_o)
        end
        acc(1, SPCB_ADDR_TRACK_MODE, 16'h0001);
        rd(SPCB_ADDR_TRACK_MODE, 16'h0001);
        step(2);
        `CHK("mode_held", 2'b00, {absolute_mode_o, wrong_motor_alarm_o})
        do_reset(1);
        `CHK("mode_abs", 2'b11, {absolute_mode_o, wrong_motor_alarm_o})
        motor_is_absolute_i = 1;
        step(2);
        `CHK("mode_abs_ok", 2'b10, {absolute_mode_o, wrong_motor_alarm_o})
        do_reset(0);
        `CHK("mode_inc", 2'b00, {absolute_mode_o, wrong_motor_alarm_o})
        print_verdict();
    end
endmodule

/* core/spcb_bank.sv */
// servo protection config bank: parameter words and the protection logic they steer
//
// What this block does
// - special word one bit 9 set enables broken motor phase wire detection.
// - special word one bit 12 clear raises phase loss alarm; set disables it.
// - special word one bit 13 clear raises encoder output alarm; set disables.
// - below zero speed, bit 15 set zeroes friction compensation, clear keeps it.
// - special word two bit 2: undervoltage latches until cleared, or self-clears.
// - special word two bit 4 set suppresses the ignorable fault alarm.
// - undervoltage drives warning pin, or alarm pin when word two bit 9 set.
// - semi-auto inertia estimate held below threshold long enough means complete.
// - tracking mode 0 runs every motor as incremental.
// - tracking mode 1 is absolute; incremental motor raises wrong motor alarm.
// - new tracking mode takes effect only after next power-up.
// - readback bit 0 picks pulse or user units for digital I/O positions.
// - readback bit 1 picks pulse or user units for communication positions.
// - readback bit 2 set suppresses overflow warnings, else unit-matched warning.
// - writing 1 to home-set with function code 271 sets home position.
`timescale 1ns/1ns
module spcb_bank
    import spcb_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = SPCB_SETTLE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // parameter access port (panel or communication)
    input wire logic par_wr_i,
    input wire logic par_rd_i,
    input wire logic [SPCB_AW-1:0] par_addr_i,
    input wire logic [SPCB_DW-1:0] par_wdata_i,
    output logic [SPCB_DW-1:0] par_rdata_o,
    output logic par_ack_o,
    output logic par_err_o,
    // values restored at power-up and other drive state
    input wire logic nv_track_mode_i,
    input wire logic [15:0] special_function_code_i,
    input wire logic motor_is_absolute_i,
    input wire logic semi_auto_mode_i,
    input wire logic [15:0] inertia_estimate_i,
    input wire logic speed_below_zero_threshold_i,
    input wire logic [15:0] friction_comp_i,
    // raw detector inputs
    input wire logic pulse_err_det_i,
    input wire logic wire_cut_det_i,
    input wire logic phase_loss_det_i,
    input wire logic encoder_output_det_i,
    input wire logic ignorable_fault_det_i,
    input wire logic undervoltage_det_i,
    input wire logic alarm_clear_i,
    input wire logic position_overflow_i,
    // results
    output logic pulse_err_alarm_o,
    output logic wire_cut_alarm_o,
    output logic phase_loss_alarm_o,
    output logic encoder_output_alarm_o,
    output logic ignorable_fault_alarm_o,
    output logic undervoltage_alarm_o,
    output logic alarm_output_pin_o,
    output logic warning_output_pin_o,
    output logic wrong_motor_alarm_o,
    output logic absolute_mode_o,
    output logic [15:0] friction_comp_o,
    output logic dio_unit_pulse_o,
    output logic comm_unit_pulse_o,
    output logic user_unit_overflow_warning_o,
    output logic pulse_unit_overflow_warning_o,
    output logic inertia_done_o,
    output logic home_set_o
);
    logic [15:0] special_bits_one_r;
    logic [15:0] special_bits_two_r;
    logic [15:0] inertia_settle_threshold_r;
    logic position_tracking_mode_r;
    logic track_active_r;
    logic [15:0] readback_unit_select_r;
    logic powerup_done_r;
    logic uv_latch_r;
    logic uv_latch_nxt;
    logic settle_done;

    // address decode
    wire hit_one = (par_addr_i == SPCB_ADDR_SPECIAL_ONE);
    wire hit_two = (par_addr_i == SPCB_ADDR_SPECIAL_TWO);
    wire hit_thr = (par_addr_i == SPCB_ADDR_SETTLE_THR);
    wire hit_mode = (par_addr_i == SPCB_ADDR_TRACK_MODE);
    wire hit_unit = (par_addr_i == SPCB_ADDR_READBACK_UNIT);
    wire hit_home = (par_addr_i == SPCB_ADDR_HOME_SET);
    wire hit_any = hit_one || hit_two || hit_thr || hit_mode || hit_unit || hit_home;
    wire access = par_wr_i || par_rd_i;
    wire wr_ok = par_wr_i && hit_any;

    // out-of-range threshold writes are refused so the settle compare stays meaningful
    wire thr_ok = (par_wdata_i <= SPCB_SETTLE_THR_MAX);
    localparam logic [15:0] HOME_TRIGGER = 16'h0001;
    wire home_req = wr_ok && hit_home && (par_wdata_i == HOME_TRIGGER) &&
                    (special_function_code_i == SPCB_HOME_FUNC_CODE);

    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (hit_one) begin
            rd_mux = special_bits_one_r;
        end else if (hit_two) begin
            rd_mux = special_bits_two_r;
        end else if (hit_thr) begin
            rd_mux = inertia_settle_threshold_r;
        end else if (hit_mode) begin
            rd_mux = {15'h0000, position_tracking_mode_r};
        end else if (hit_unit) begin
            rd_mux = readback_unit_select_r;
        end
    end

    // the stored register reloads from the non-volatile copy at power-up, then tracks writes;
    // software never reaches track_active_r, so a new mode only acts after re-power
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            position_tracking_mode_r <= SPCB_TRACK_INCREMENTAL;
            track_active_r <= SPCB_TRACK_INCREMENTAL;
            powerup_done_r <= 1'b0;
        end else begin
            powerup_done_r <= 1'b1;
            if (!powerup_done_r) begin
                position_tracking_mode_r <= nv_track_mode_i;
                track_active_r <= nv_track_mode_i;
            end else if (wr_ok && hit_mode) begin
                position_tracking_mode_r <= par_wdata_i[0];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            special_bits_one_r <= SPCB_RST_SPECIAL_ONE;
            special_bits_two_r <= SPCB_RST_SPECIAL_TWO;
            inertia_settle_threshold_r <= SPCB_RST_SETTLE_THR;
            readback_unit_select_r <= SPCB_RST_READBACK_UNIT;
        end else begin
            if (wr_ok && hit_one) begin
                special_bits_one_r <= par_wdata_i & SPCB_MASK_SPECIAL_ONE;
            end
            if (wr_ok && hit_two) begin
                special_bits_two_r <= par_wdata_i & SPCB_MASK_SPECIAL_TWO;
            end
            if (wr_ok && hit_thr && thr_ok) begin
                inertia_settle_threshold_r <= par_wdata_i;
            end
            if (wr_ok && hit_unit) begin
                // reserved upper bits are dropped even if software sets them
                readback_unit_select_r <= par_wdata_i & SPCB_MASK_READBACK_UNIT;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            par_rdata_o <= 16'h0000;
            par_ack_o <= 1'b0;
            par_err_o <= 1'b0;
            home_set_o <= 1'b0;
        end else begin
            par_rdata_o <= (par_rd_i && hit_any) ? rd_mux : 16'h0000;
            par_ack_o <= access && hit_any;
            par_err_o <= access && !hit_any;
            home_set_o <= home_req;
        end
    end

    // undervoltage latch: a new detection wins over a clear in the same cycle
    wire uv_autoclear = special_bits_two_r[SPCB_B2_UV_AUTOCLEAR];
    wire uv_release = uv_autoclear ? 1'b1 : alarm_clear_i;
    assign uv_latch_nxt = undervoltage_det_i || (uv_latch_r && !uv_release);
    wire uv_to_alarm = special_bits_two_r[SPCB_B2_UV_TO_ALARM];

    wire comm_pulse = readback_unit_select_r[SPCB_RU_COMM_PULSE];
    wire ovf_warn = position_overflow_i && !readback_unit_select_r[SPCB_RU_NO_OVF_WARN];
    wire friction_zero = speed_below_zero_threshold_i && special_bits_one_r[SPCB_B1_FRICTION_ZERO];

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            uv_latch_r <= 1'b0;
            undervoltage_alarm_o <= 1'b0;
            alarm_output_pin_o <= 1'b0;
            warning_output_pin_o <= 1'b0;
        end else begin
            uv_latch_r <= uv_latch_nxt;
            undervoltage_alarm_o <= uv_latch_nxt;
            alarm_output_pin_o <= uv_latch_nxt && uv_to_alarm;
            warning_output_pin_o <= uv_latch_nxt && !uv_to_alarm;
        end
    end

    // detector gates: an alarm follows its detector one cycle later while its enable holds
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pulse_err_alarm_o <= 1'b0;
            wire_cut_alarm_o <= 1'b0;
            phase_loss_alarm_o <= 1'b0;
            encoder_output_alarm_o <= 1'b0;
            ignorable_fault_alarm_o <= 1'b0;
        end else begin
            pulse_err_alarm_o <= pulse_err_det_i && !special_bits_one_r[SPCB_B1_PULSE_ERR_DIS];
            wire_cut_alarm_o <= wire_cut_det_i && special_bits_one_r[SPCB_B1_WIRE_CUT_EN];
            phase_loss_alarm_o <= phase_loss_det_i && !special_bits_one_r[SPCB_B1_PHASE_LOSS_DIS];
            encoder_output_alarm_o <= encoder_output_det_i && !special_bits_one_r[SPCB_B1_ENC_OUT_DIS];
            ignorable_fault_alarm_o <= ignorable_fault_det_i && !special_bits_two_r[SPCB_B2_IGNORE_MASK];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wrong_motor_alarm_o <= 1'b0;
            absolute_mode_o <= 1'b0;
            friction_comp_o <= 16'h0000;
            dio_unit_pulse_o <= 1'b0;
            comm_unit_pulse_o <= 1'b0;
            user_unit_overflow_warning_o <= 1'b0;
            pulse_unit_overflow_warning_o <= 1'b0;
        end else begin
            // only the mode captured at power-up steers the drive
            absolute_mode_o <= track_active_r;
            wrong_motor_alarm_o <= powerup_done_r && track_active_r && !motor_is_absolute_i;
            friction_comp_o <= friction_zero ? 16'h0000 : friction_comp_i;
            dio_unit_pulse_o <= readback_unit_select_r[SPCB_RU_DIO_PULSE];
            comm_unit_pulse_o <= comm_pulse;
            user_unit_overflow_warning_o <= ovf_warn && !comm_pulse;
            pulse_unit_overflow_warning_o <= ovf_warn && comm_pulse;
        end
    end

    spcb_settle_timer #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_settle (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .enable_i(semi_auto_mode_i),
        .estimate_i(inertia_estimate_i),
        .threshold_i(inertia_settle_threshold_r),
        .done_o(settle_done)
    );

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            inertia_done_o <= 1'b0;
        end else begin
            inertia_done_o <= settle_done;
        end
    end
endmodule

/* core/spcb_pkg.sv */
// constants, register map and field layout of the servo protection config bank
package spcb_pkg;
    localparam int unsigned SPCB_AW = 16;
    localparam int unsigned SPCB_DW = 16;

    // word addresses on the parameter access port
    localparam logic [15:0] SPCB_ADDR_SPECIAL_ONE = 16'h0282;
    localparam logic [15:0] SPCB_ADDR_SPECIAL_TWO = 16'h0284;
    localparam logic [15:0] SPCB_ADDR_SETTLE_THR = 16'h0286;
    localparam logic [15:0] SPCB_ADDR_TRACK_MODE = 16'h028a;
    localparam logic [15:0] SPCB_ADDR_READBACK_UNIT = 16'h028c;
    localparam logic [15:0] SPCB_ADDR_HOME_SET = 16'h028e;

    // reset values
    localparam logic [15:0] SPCB_RST_SPECIAL_ONE = 16'h0000;
    localparam logic [15:0] SPCB_RST_SPECIAL_TWO = 16'h0010;
    localparam logic [15:0] SPCB_RST_SETTLE_THR = 16'h000f;
    localparam logic [15:0] SPCB_RST_READBACK_UNIT = 16'h0000;

    // writable bits; everything else is reserved and reads as zero
    localparam logic [15:0] SPCB_MASK_SPECIAL_ONE = 16'hb240;
    localparam logic [15:0] SPCB_MASK_SPECIAL_TWO = 16'h0214;
    localparam logic [15:0] SPCB_MASK_READBACK_UNIT = 16'h0007;

    // field positions, special word one
    localparam int unsigned SPCB_B1_PULSE_ERR_DIS = 6;
    localparam int unsigned SPCB_B1_WIRE_CUT_EN = 9;
    localparam int unsigned SPCB_B1_PHASE_LOSS_DIS = 12;
    localparam int unsigned SPCB_B1_ENC_OUT_DIS = 13;
    localparam int unsigned SPCB_B1_FRICTION_ZERO = 15;
    // special word two
    localparam int unsigned SPCB_B2_UV_AUTOCLEAR = 2;
    localparam int unsigned SPCB_B2_IGNORE_MASK = 4;
    localparam int unsigned SPCB_B2_UV_TO_ALARM = 9;
    // readback unit word
    localparam int unsigned SPCB_RU_DIO_PULSE = 0;
    localparam int unsigned SPCB_RU_COMM_PULSE = 1;
    localparam int unsigned SPCB_RU_NO_OVF_WARN = 2;

    localparam logic [15:0] SPCB_SETTLE_THR_MAX = 16'h07d0;
    localparam logic [15:0] SPCB_HOME_FUNC_CODE = 16'h010f;

    // inertia estimate must stay below threshold this long
    localparam int unsigned SPCB_CLK_HZ = 10_000_000;
    localparam int unsigned SPCB_SETTLE_MS = 100;
    localparam int unsigned SPCB_SETTLE_CYC = SPCB_CLK_HZ / 1000 * SPCB_SETTLE_MS;

    typedef enum logic [0:0] {
        SPCB_TRACK_INCREMENTAL = 1'b0,
        SPCB_TRACK_ABSOLUTE = 1'b1
    } spcb_track_e;
endpackage

/* core/spcb_settle_timer.sv */
// inertia estimation settle detector: estimate below threshold for a sustained time
`timescale 1ns/1ns
module spcb_settle_timer
    import spcb_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = SPCB_SETTLE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    input wire logic [15:0] estimate_i,
    input wire logic [15:0] threshold_i,
    output logic done_o
);
    localparam int unsigned CW = $clog2(SETTLE_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(SETTLE_CYC - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic done_r;
    logic done_nxt;
    wire below = enable_i && (estimate_i < threshold_i);
    wire reached = (cnt_r == CNT_LAST);

    // any excursion above threshold restarts the interval
    assign cnt_nxt = !below ? '0 : (reached ? cnt_r : cnt_r + CW'(1));
    assign done_nxt = below && (reached || done_r);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done_o = done_r;
endmodule
